// ==== logic/afsp_pkg.sv ====
// shared constants and types of the framed serial converter port
package afsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // apb register map (byte addresses)
  localparam logic [7:0]  REG_CTRL       = 8'h00;  // control: low power mode
  localparam logic [7:0]  REG_STATUS     = 8'h04;  // live block state
  localparam logic [7:0]  REG_IRQ_STAT   = 8'h08;  // sticky events, read clears
  localparam logic [7:0]  REG_IRQ_MASK   = 8'h0C;  // event enables
  localparam logic [7:0]  REG_LAST_WRITE = 8'h10;  // last serial write word

  // field positions
  localparam int          CTRL_LP_BIT    = 0;      // low power mode
  localparam int          ST_OVR_BIT     = 0;      // overrange level
  localparam int          ST_DEC_LSB     = 1;      // decimation pin code, 2 bits
  localparam int          ST_RXBUSY_BIT  = 3;      // serial write in progress
  localparam int          ST_TXBUSY_BIT  = 4;      // output frame in progress
  localparam int          EV_FRAME       = 0;      // output word sent
  localparam int          EV_WRITE       = 1;      // serial write received
  localparam int          EV_RESTART     = 2;      // filter restart seen
  localparam int          EV_OVR         = 3;      // overrange went high
  localparam int          NUM_EV         = 4;

  // reset values
  localparam logic        CTRL_LP_RST    = 1'b0;
  localparam logic [3:0]  IRQ_MASK_RST   = 4'h0;

  // serial write decode: address word that reaches the control register
  localparam logic [15:0] SER_CTRL_ADDR  = 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // decimation pin codes and ratios
  localparam logic [1:0]  DEC_SEL_256    = 2'b00;  // pin tied to ground
  localparam logic [1:0]  DEC_SEL_64     = 2'b01;  // pin tied to supply
  localparam logic [1:0]  DEC_SEL_128    = 2'b10;  // pin left open
  localparam logic [7:0]  DEC_LIM_64     = 8'h3F;  // ratio 64 minus one
  localparam logic [7:0]  DEC_LIM_128    = 8'h7F;  // ratio 128 minus one
  localparam logic [7:0]  DEC_LIM_256    = 8'hFF;  // ratio 256 minus one

  ////////////////////////////////////////////////////////////////////////////
  // timing: master clock cycles per modulator clock period
  localparam int          NORM_DIV       = 2;      // normal power mode
  localparam int          LP_DIV         = 4;      // low power mode
  localparam logic [1:0]  NORM_HALF_M1   = 2'(NORM_DIV / 2 - 1);
  localparam logic [1:0]  LP_HALF_M1     = 2'(LP_DIV / 2 - 1);
  localparam int          FRAME_BITS     = 32;     // bits per output word
  localparam logic [5:0]  FRAME_BITS_C   = 6'(FRAME_BITS);
  localparam logic [4:0]  WRITE_LAST     = 5'h1F;  // last bit index of a write
  localparam logic [3:0]  STATUS_PAD     = 4'h0;   // spare status bits
  localparam logic [7:0]  LOW_TIME_NORM  = 8'(FRAME_BITS * NORM_DIV);
  localparam logic [7:0]  LOW_TIME_LP    = 8'(FRAME_BITS * LP_DIV);

  ////////////////////////////////////////////////////////////////////////////
  // serial write receiver states
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_SHIFT = 3'b010,
    RX_APPLY = 3'b100
  } afsp_rx_e;

  // apb request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } afsp_apb_req_s;

  // apb answer bundle
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } afsp_apb_rsp_s;

  // whole state of the block
  typedef struct packed {
    logic                sco;        // serial clock out
    logic                strobeN;    // output frame strobe, low in frame
    logic                txBit;      // serial data out
    logic                ovr;        // overrange out
    logic                irq;        // interrupt out
    afsp_apb_rsp_s       rsp;        // bus answer
    logic                lowPower;   // control bit
    logic [NUM_EV-1:0]   irqStat;    // sticky events
    logic [NUM_EV-1:0]   irqMask;    // event enables
    logic [1:0]          divCnt;     // half period counter
    logic [7:0]          decCnt;     // modulator periods per word
    logic [7:0]          decLimit;   // ratio minus one from pin
    logic [31:0]         txShift;    // output shifter
    logic [5:0]          txCnt;      // bits launched
    logic                txBusy;     // frame in progress
    afsp_rx_e            rx;         // write receiver state
    logic [4:0]          rxCnt;      // bits captured
    logic [31:0]         rxShift;    // input shifter
    logic [31:0]         lastWrite;  // last complete write
    logic                restartPrev;// filter restart, previous level
  } afsp_state_s;

endpackage

// ==== logic/afsp_top.sv ====
// Contract
// - overrange out high while input nears limit
// - serial clock equals modulator clock rate
// - output frame lasts exactly 32 clock periods
// - output bits launched on serial clock rise
// - each word carries data plus status
// - input strobe sampled low on falling edge
// - first write bit taken next falling edge
// - write is address word then data word
// - restart falling edge resets digital filter
// - chip off low holds circuitry in reset
// - rate pin selects 64, 128, 256
// - low power divides master clock by four
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module afsp_top
  import afsp_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire afsp_apb_req_s apbReq,
  output afsp_apb_rsp_s      apbRsp,
  output logic               irq,
  input  wire logic [23:0]   convData,
  input  wire logic          ovrIn,
  input  wire logic          chipOffN,
  input  wire logic [1:0]    decimationSelect,
  input  wire logic          filterRestartN,
  input  wire logic          inputFrameStrobeN,
  input  wire logic          serialDataIn,
  output logic               serialClockOut,
  output logic               outputFrameStrobeN,
  output logic               serialDataOut,
  output logic               overrange
);

  ////////////////////////////////////////////////////////////////////////////
  // state and edge events
  afsp_state_s st_reg;      // registered state
  afsp_state_s st_next;     // next state
  logic        toggle;      // half period ends this cycle
  logic        riseEv;      // serial clock rises at this edge
  logic        fallEv;      // serial clock falls at this edge
  logic        setup;       // apb setup phase
  logic        done;        // apb transfer completes
  logic [31:0] rdData;      // read mux
  logic        mapped;      // address decodes
  logic [NUM_EV-1:0] ev;    // events this cycle
  logic [NUM_EV-1:0] clr;   // bits cleared by a status read

  // modulator clock phase, divider depends on power mode
  assign toggle = st_reg.divCnt == (st_reg.lowPower ? LP_HALF_M1 : NORM_HALF_M1);
  assign riseEv = toggle && !st_reg.sco;
  assign fallEv = toggle && st_reg.sco;
  assign setup  = apbReq.psel && !apbReq.penable;
  assign done   = apbReq.psel && apbReq.penable && st_reg.rsp.pready;

  ////////////////////////////////////////////////////////////////////////////
  // register read mux and decode
  always_comb begin
    rdData = 32'h0000_0000;
    mapped = 1'b1;
    case (apbReq.paddr)
      REG_CTRL: begin
        rdData[CTRL_LP_BIT] = st_reg.lowPower;
      end
      REG_STATUS: begin
        rdData[ST_OVR_BIT]              = st_reg.ovr;
        rdData[ST_DEC_LSB +: 2]         = decimationSelect;
        rdData[ST_RXBUSY_BIT]           = !st_reg.rx[0];
        rdData[ST_TXBUSY_BIT]           = st_reg.txBusy;
      end
      REG_IRQ_STAT: begin
        rdData[NUM_EV-1:0] = st_reg.irqStat;
      end
      REG_IRQ_MASK: begin
        rdData[NUM_EV-1:0] = st_reg.irqMask;
      end
      REG_LAST_WRITE: begin
        rdData = st_reg.lastWrite;
      end
      default: begin
        mapped = 1'b0;  // unmapped: zero data, error
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_next = st_reg;
    ev      = '0;
    clr     = '0;

    // bus answer: one wait-free access phase after setup
    st_next.rsp.pready  = setup;
    st_next.rsp.prdata  = setup ? rdData : 32'h0000_0000;
    st_next.rsp.pslverr = setup && !mapped;

    // bus writes at the completing edge
    if (done && apbReq.pwrite) begin
      case (apbReq.paddr)
        REG_CTRL:     st_next.lowPower = apbReq.pwdata[CTRL_LP_BIT];
        REG_IRQ_MASK: st_next.irqMask  = apbReq.pwdata[NUM_EV-1:0];
        default:      st_next.lowPower = st_reg.lowPower;
      endcase
    end
    // status read clears only the bits it returned
    if (done && !apbReq.pwrite && apbReq.paddr == REG_IRQ_STAT) begin
      clr = st_reg.rsp.prdata[NUM_EV-1:0];
    end

    // overrange pin follows the modulator limit detector
    st_next.ovr = ovrIn;
    ev[EV_OVR]  = ovrIn && !st_reg.ovr;

    // rate pin sets modulator periods per word
    case (decimationSelect)
      DEC_SEL_64:  st_next.decLimit = DEC_LIM_64;
      DEC_SEL_128: st_next.decLimit = DEC_LIM_128;
      default:     st_next.decLimit = DEC_LIM_256;
    endcase

    // serial clock runs at the modulator clock rate
    if (toggle) begin
      st_next.divCnt = 2'b00;
      st_next.sco    = !st_reg.sco;
    end else begin
      st_next.divCnt = st_reg.divCnt + 2'b01;
    end

    // output framing on serial clock rises
    if (riseEv) begin
      st_next.decCnt = (st_reg.decCnt == st_reg.decLimit) ? 8'h00 : st_reg.decCnt + 8'h01;
      if (st_reg.txBusy) begin
        if (st_reg.txCnt == FRAME_BITS_C) begin
          // strobe returns high after 32 periods
          st_next.strobeN = 1'b1;
          st_next.txBusy  = 1'b0;
          st_next.txBit   = 1'b0;
          ev[EV_FRAME]    = 1'b1;
        end else begin
          st_next.txBit   = st_reg.txShift[31];
          st_next.txShift = {st_reg.txShift[30:0], 1'b0};
          st_next.txCnt   = st_reg.txCnt + 6'h01;
        end
      end else if (st_reg.decCnt == st_reg.decLimit) begin
        // word: conversion data then status byte
        st_next.txShift = {convData[22:0], st_reg.ovr, st_reg.lowPower, decimationSelect, STATUS_PAD, 1'b0};
        st_next.txBit   = convData[23];
        st_next.txCnt   = 6'h01;
        st_next.txBusy  = 1'b1;
        st_next.strobeN = 1'b0;
      end
    end

    // serial write receiver on serial clock falls
    case (st_reg.rx)
      RX_IDLE: begin
        if (fallEv && !inputFrameStrobeN) begin
          st_next.rx    = RX_SHIFT;
          st_next.rxCnt = 5'h00;
        end
      end
      RX_SHIFT: begin
        if (fallEv) begin
          st_next.rxShift = {st_reg.rxShift[30:0], serialDataIn};
          st_next.rxCnt   = st_reg.rxCnt + 5'h01;
          if (st_reg.rxCnt == WRITE_LAST) begin
            st_next.rx = RX_APPLY;
          end
        end
      end
      RX_APPLY: begin
        // address word high, data word low
        st_next.lastWrite = st_reg.rxShift;
        ev[EV_WRITE]      = 1'b1;
        st_next.rx        = RX_IDLE;
        if (st_reg.rxShift[31:16] == SER_CTRL_ADDR && !(done && apbReq.pwrite && apbReq.paddr == REG_CTRL)) begin
          st_next.lowPower = st_reg.rxShift[CTRL_LP_BIT];
        end
      end
      default: begin
        st_next.rx = RX_IDLE;
      end
    endcase

    // filter restart on a falling edge of the restart pin
    st_next.restartPrev = filterRestartN;
    if (st_reg.restartPrev && !filterRestartN) begin
      st_next.decCnt  = 8'h00;
      ev[EV_RESTART]  = 1'b1;
    end

    // chip off holds the converter side in reset
    if (!chipOffN) begin
      st_next.sco         = 1'b0;
      st_next.strobeN     = 1'b1;
      st_next.txBit       = 1'b0;
      st_next.ovr         = 1'b0;
      st_next.divCnt      = 2'b00;
      st_next.decCnt      = 8'h00;
      st_next.txShift     = 32'h0000_0000;
      st_next.txCnt       = 6'h00;
      st_next.txBusy      = 1'b0;
      st_next.rx          = RX_IDLE;
      st_next.rxCnt       = 5'h00;
      st_next.restartPrev = 1'b1;
      ev                  = '0;
    end

    // sticky events: a new event beats a clearing read
    st_next.irqStat = (st_reg.irqStat & ~clr) | ev;
    st_next.irq     = |(st_next.irqStat & st_next.irqMask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg             <= '0;
      st_reg.strobeN     <= 1'b1;
      st_reg.lowPower    <= CTRL_LP_RST;
      st_reg.irqMask     <= IRQ_MASK_RST;
      st_reg.decLimit    <= DEC_LIM_256;
      st_reg.rx          <= RX_IDLE;
      st_reg.restartPrev <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from state flops
  assign apbRsp             = st_reg.rsp;
  assign irq                = st_reg.irq;
  assign serialClockOut     = st_reg.sco;
  assign outputFrameStrobeN = st_reg.strobeN;
  assign serialDataOut      = st_reg.txBit;
  assign overrange          = st_reg.ovr;

  ////////////////////////////////////////////////////////////////////////////
  // checking helpers: frame low time and mode change during a frame
  logic [7:0] lowCyc;   // cycles the frame strobe has been low
  logic       lpChg;    // power mode changed during this frame
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lowCyc <= 8'h00;
      lpChg  <= 1'b0;
    end else begin
      lowCyc <= st_reg.strobeN ? 8'h00 : lowCyc + 8'h01;
      lpChg  <= st_reg.strobeN ? 1'b0 : (lpChg || st_next.lowPower != st_reg.lowPower);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // overrange pin follows the detector one cycle later
  property p_ovr_follow;
    chipOffN |=> (overrange == $past(ovrIn));
  endproperty
  a_ovr_follow: assert property (p_ovr_follow) else $error("overrange does not follow detector");

  // normal mode: serial clock high one cycle, low one cycle
  property p_sco_norm;
    ($rose(serialClockOut) && !st_reg.lowPower && chipOffN) |=> (!serialClockOut || !chipOffN);
  endproperty
  a_sco_norm: assert property (p_sco_norm) else $error("serial clock period wrong in normal mode");

  // low power: serial clock high two cycles, low two cycles
  sequence s_lp_rise;
    $rose(serialClockOut) && st_reg.lowPower && $past(st_reg.lowPower) && chipOffN;
  endsequence
  property p_sco_lp;
    s_lp_rise |-> ##1 (serialClockOut || !chipOffN) ##1 (!serialClockOut || !chipOffN);
  endproperty
  a_sco_lp: assert property (p_sco_lp) else $error("serial clock period wrong in low power");

  // frame strobe stays low for 32 serial clock periods
  property p_strobe_width;
    ($rose(outputFrameStrobeN) && chipOffN && !$past(lpChg) && $past(chipOffN))
      |-> (lowCyc == (st_reg.lowPower ? LOW_TIME_LP : LOW_TIME_NORM));
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("output frame width wrong");

  // output bit changes only with a rising serial clock
  property p_bit_launch;
    ($changed(serialDataOut) && chipOffN) |-> $rose(serialClockOut);
  endproperty
  a_bit_launch: assert property (p_bit_launch) else $error("output bit launched off the rising edge");

  // frame opens with the data msb
  property p_word_msb;
    ($fell(outputFrameStrobeN) && chipOffN) |-> (serialDataOut == $past(convData[23]));
  endproperty
  a_word_msb: assert property (p_word_msb) else $error("frame does not open with data msb");

  // strobe low at a falling edge opens a write
  sequence s_write_start;
    (st_reg.rx == RX_IDLE) && fallEv && !inputFrameStrobeN && chipOffN;
  endsequence
  property p_write_start;
    s_write_start |=> (st_reg.rx == RX_SHIFT) && (st_reg.rxCnt == 5'h00);
  endproperty
  a_write_start: assert property (p_write_start) else $error("write not started by frame strobe");

  // each following falling edge captures the data pin
  property p_write_bit;
    ((st_reg.rx == RX_SHIFT) && fallEv && chipOffN) |=> (st_reg.rxShift[0] == $past(serialDataIn));
  endproperty
  a_write_bit: assert property (p_write_bit) else $error("write bit not captured");

  // 32 captured bits complete one write
  property p_write_len;
    ((st_reg.rx == RX_SHIFT) && fallEv && st_reg.rxCnt == WRITE_LAST && chipOffN)
      |=> (st_reg.rx == RX_APPLY) ##1 (st_reg.lastWrite == $past(st_reg.rxShift));
  endproperty
  a_write_len: assert property (p_write_len) else $error("write not 32 bits");

  // restart falling edge clears the filter phase
  property p_restart;
    (st_reg.restartPrev && !filterRestartN && chipOffN) |=> (st_reg.decCnt == 8'h00);
  endproperty
  a_restart: assert property (p_restart) else $error("filter not reset by restart");

  // chip off quiets every converter output
  property p_chip_off;
    !chipOffN |=> (outputFrameStrobeN && !serialClockOut && !serialDataOut && !overrange);
  endproperty
  a_chip_off: assert property (p_chip_off) else $error("outputs active while chip off");

  // rate pin code for 64 sets the ratio 64 word spacing limit
  property p_rate_pin;
    (decimationSelect == DEC_SEL_64) |=> (st_reg.decLimit == DEC_LIM_64);
  endproperty
  a_rate_pin: assert property (p_rate_pin) else $error("rate pin not applied");

  // frame strobe moves only together with a rising serial clock
  property p_strobe_edge;
    ($changed(outputFrameStrobeN) && chipOffN && $past(chipOffN)) |-> $rose(serialClockOut);
  endproperty
  a_strobe_edge: assert property (p_strobe_edge) else $error("frame strobe moved off a rising clock");

endmodule

// ==== dv/afsp_host.sv ====
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// host side: takes output words, sends serial writes, pulses filter restart
module afsp_host (
  input  wire logic        clk,
  input  wire logic        serClk,
  input  wire logic        outStrobeN,
  input  wire logic        outData,
  input  wire logic        wrGo,
  input  wire logic [31:0] wrWord,
  input  wire logic        restartGo,
  output logic             inStrobeN,
  output logic             inData,
  output logic             restartN,
  output logic             wrBusy,
  output logic             wordValid,
  output logic [31:0]      word
);
  int wrIdx;      // write bits still to present
  int rxCnt = 0;  // bits taken of the current word
  int rsCnt = 0;  // restart low cycles left

  // quiet levels at time zero
  initial begin
    inStrobeN = 1'b1;
    inData    = 1'b0;
    restartN  = 1'b1;
    wrBusy    = 1'b0;
    wordValid = 1'b0;
    word      = '0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // all moves just after a serial clock fall, so each level stands a period
  always @(negedge serClk) begin
    wordValid <= 1'b0;
    if (!outStrobeN) begin
      word <= {word[30:0], outData};  // msb first
      rxCnt++;
      if (rxCnt == 32) begin          // whole word taken
        wordValid <= 1'b1;
        rxCnt = 0;
      end
    end else begin
      rxCnt = 0;
    end
    if (!wrBusy && wrGo) begin        // strobe low for one period opens a write
      inStrobeN <= 1'b0;
      wrBusy    <= 1'b1;
      wrIdx = 32;
    end else if (wrBusy && wrIdx > 0) begin
      inStrobeN <= 1'b1;
      inData    <= wrWord[wrIdx-1];
      wrIdx--;
    end else begin                    // idle: the line toggles every period
      inData <= ~inData;
      wrBusy <= 1'b0;
    end
  end

  // restart held low four master clock periods
  always @(posedge clk) begin
    if (rsCnt > 0) begin
      rsCnt--;
      restartN <= (rsCnt == 0);
    end else if (restartGo) begin
      rsCnt = 4;
      restartN <= 1'b0;
    end
  end
endmodule

// ==== dv/tb_adc_frame_serial_port.sv ====
`timescale 1ns/10ps
module tb_adc_frame_serial_port
  import afsp_pkg::*;
;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;  // compare every bit
  logic          clk = 1'b0, arst_n = 1'b0, ovrIn = 1'b0, chipOffN = 1'b1;
  logic          wrGo = 1'b0, restartGo = 1'b0, expLp = 1'b0;
  logic          irq, serClk, outStrobeN, outData, overrange, inStrobeN, inData, restartN, wrBusy, wordValid;
  logic          strobePrev = 1'b1, clkPrev = 1'b0, dataPrev = 1'b0;
  afsp_apb_req_s apbReq = '0;
  afsp_apb_rsp_s apbRsp;
  logic [23:0]   convData = '0;
  logic [1:0]    decSel = DEC_SEL_64;
  logic [31:0]   wrWord = '0, word;
  logic [64:0]   apbNote;
  logic [31:0]   wordQ[$];  // expected output words
  logic [64:0]   apbQ[$];   // mask, data, error per transfer
  logic [1:0]    codes[4] = '{DEC_SEL_64, DEC_SEL_128, DEC_SEL_256, 2'b11};
  int            ratio[4] = '{64, 128, 256, 256};
  int            gap, lastGap, lowCnt, lastLow, hiCnt, lastHi, failCount = 0, samplesChecked = 0;

  always #2.5 clk = ~clk;

  afsp_top dut (.clk(clk), .arst_n(arst_n), .apbReq(apbReq), .apbRsp(apbRsp), .irq(irq),
    .convData(convData), .ovrIn(ovrIn), .chipOffN(chipOffN), .decimationSelect(decSel),
    .filterRestartN(restartN), .inputFrameStrobeN(inStrobeN), .serialDataIn(inData),
    .serialClockOut(serClk), .outputFrameStrobeN(outStrobeN), .serialDataOut(outData),
    .overrange(overrange));

  afsp_host host (.clk(clk), .serClk(serClk), .outStrobeN(outStrobeN), .outData(outData),
    .wrGo(wrGo), .wrWord(wrWord), .restartGo(restartGo), .inStrobeN(inStrobeN),
    .inData(inData), .restartN(restartN), .wrBusy(wrBusy), .wordValid(wordValid), .word(word));

  //////////////////////////////////////////////////////////////////////////////
  // compare, verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic endSim;
    if (failCount == 0 && samplesChecked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one bus transfer; the note is checked by the bus watcher
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                     input logic [31:0] mask, input logic err);
    apbQ.push_back({mask, data & mask, err});
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: data};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (apbRsp.pready !== 1'b1);  // only the watchdog ends a hang
    apbReq <= '0;
    @(posedge clk);
  endtask

  // serial write through the host, then read back the word and its event
  task automatic serWrite(input logic [31:0] w);
    wrWord <= w;
    wrGo   <= 1'b1;
    while (wrBusy !== 1'b1) @(posedge clk);
    wrGo <= 1'b0;
    while (wrBusy !== 1'b0) @(posedge clk);
    apb(1'b0, REG_LAST_WRITE, w, ALL, 1'b0);
    apb(1'b0, REG_IRQ_STAT, 32'h1 << EV_WRITE, 32'h1 << EV_WRITE, 1'b0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // watchers: word notes at frame open, new sample value after each frame
  always @(negedge outStrobeN) if (arst_n) wordQ.push_back({convData, ovrIn, expLp, decSel, STATUS_PAD});
  always @(posedge outStrobeN) convData <= 24'($urandom);

  always @(posedge wordValid) begin
    if (wordQ.size() == 0) check(1'b0, 1'b1, "word with no frame");
    else check(word, wordQ.pop_front(), "output word");
  end

  always @(posedge clk) begin
    if (apbReq.psel && apbReq.penable && apbRsp.pready === 1'b1) begin
      apbNote = apbQ.pop_front();
      check(apbRsp.prdata & apbNote[64:33], apbNote[32:1], "read data");
      check(apbRsp.pslverr, apbNote[0], "error flag");
    end
  end

  // strobe and clock run lengths, word spacing, launch edge of data
  always @(posedge clk) begin
    gap++;
    if (!outStrobeN) lowCnt++;
    else if (lowCnt > 0) begin
      lastLow = lowCnt;
      lowCnt  = 0;
    end
    if (serClk) hiCnt++;
    else if (hiCnt > 0) begin
      lastHi = hiCnt;
      hiCnt  = 0;
    end
    if (!outStrobeN && strobePrev) begin
      lastGap = gap;
      gap     = 0;
    end
    if (arst_n && chipOffN && outData !== dataPrev && !(serClk && !clkPrev))
      check(1'b0, 1'b1, "data moved off rising edge");
    strobePrev = outStrobeN;
    clkPrev    = serClk;
    dataPrev   = outData;
  end

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'hA07A1FE6));
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, REG_CTRL, 32'(CTRL_LP_RST), ALL, 1'b0);
    apb(1'b0, REG_IRQ_MASK, 32'(IRQ_MASK_RST), ALL, 1'b0);
    apb(1'b0, 8'h20, '0, ALL, 1'b1);
    // every rate code
    for (int i = 0; i < 4; i++) begin
      @(posedge outStrobeN);
      decSel <= codes[i];
      repeat (3) @(negedge outStrobeN);
      check(lastGap, ratio[i] * NORM_DIV, "spacing");
      check(lastLow, FRAME_BITS * NORM_DIV, "strobe time");
      check(lastHi, NORM_DIV / 2, "clock high");
    end
    // low power over the bus
    @(posedge outStrobeN);
    decSel <= DEC_SEL_64;
    apb(1'b1, REG_CTRL, 32'h1, '0, 1'b0);
    expLp <= 1'b1;
    repeat (3) @(negedge outStrobeN);
    check(lastGap, 64 * LP_DIV, "lp spacing");
    check(lastLow, FRAME_BITS * LP_DIV, "lp strobe time");
    check(lastHi, LP_DIV / 2, "lp clock high");
    // serial writes: control word, then another address
    @(posedge outStrobeN);
    decSel <= DEC_SEL_256;
    serWrite({SER_CTRL_ADDR, 16'h0000});
    expLp <= 1'b0;
    apb(1'b0, REG_CTRL, '0, ALL, 1'b0);
    @(posedge outStrobeN);
    serWrite({16'h8000 | 16'($urandom), 16'($urandom)});
    repeat (2) @(negedge outStrobeN);
    check(lastHi, NORM_DIV / 2, "normal clock again");
    // filter restart, only its event unmasked
    apb(1'b1, REG_IRQ_MASK, 32'h1 << EV_RESTART, '0, 1'b0);
    @(negedge outStrobeN);
    repeat (100) @(posedge clk);
    restartGo <= 1'b1;
    @(posedge clk);
    restartGo <= 1'b0;
    repeat (8) @(posedge clk);
    check(irq, 1'b1, "irq on restart");
    repeat (2) @(negedge outStrobeN);
    check(lastGap > 256 * NORM_DIV, 1'b1, "restart realigns");
    apb(1'b0, REG_IRQ_STAT, 32'h1 << EV_RESTART, 32'h1 << EV_RESTART, 1'b0);
    repeat (3) @(posedge clk);
    check(irq, 1'b0, "irq cleared");
    // overrange, its event masked
    @(posedge outStrobeN);
    ovrIn <= 1'b1;
    repeat (3) @(posedge clk);
    check(overrange, 1'b1, "overrange");
    check(irq, 1'b0, "masked event");
    apb(1'b0, REG_STATUS, 32'h1 | (32'(decSel) << ST_DEC_LSB), 32'hF, 1'b0);
    apb(1'b0, REG_IRQ_STAT, 32'h1 << EV_OVR, 32'h1 << EV_OVR, 1'b0);
    repeat (2) @(negedge outStrobeN);
    // power down parks the pins
    @(posedge outStrobeN);
    chipOffN <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      repeat (150) @(posedge clk);
      check({serClk, outStrobeN, outData, overrange}, 4'b0100, "parked");
    end
    chipOffN <= 1'b1;
    ovrIn    <= 1'b0;
    repeat (2) @(negedge outStrobeN);
    @(posedge clk);
    endSim();
  end

  // hang guard, well past the expected run
  initial begin
    #200000;
    failCount++;
    endSim();
  end
endmodule
